// >>> branch_timing_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "branch_timing_cfg.svh"
module branch_timing_core import branch_timing_pkg::*; (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire sfr_req_type sfr_req,
  input wire logic op_start,
  input wire logic [7:0] opcode,
  output logic [7:0] sfr_rdata,
  output logic [15:0] active_data_pointer,
  output logic [1:0] op_bytes,
  output logic op_writes_carry,
  output logic op_busy,
  output logic op_done,
  output logic icycle_tick,
  output logic timer_tick,
  output logic data_strobe
);
  // Bytes, instruction cycles and carry use per opcode
  function automatic op_info_type decode(input logic [7:0] op);
    op_info_type r;
    r = '{nbytes: 2'h1, ncycles: 3'h1, is_ext_move: 1'b0, writes_carry: 1'b0, is_nop: 1'b0};
    if (op[4:0] == 5'h11 || op[4:0] == 5'h01) begin
      r.nbytes = 2'h2;
      r.ncycles = 3'h3;
    end else if (op[7:3] == 5'h1B) begin
      r.nbytes = 2'h2;
      r.ncycles = 3'h3;
    end else if (op[7:3] == 5'h17 || op[7:1] == 7'h5B) begin
      r.nbytes = 2'h3;
      r.ncycles = 3'h4;
      r.writes_carry = 1'b1;
    end else if (op == 8'hE0 || op == 8'hF0 || op[7:1] == 7'h71 || op[7:1] == 7'h79) begin
      r.ncycles = 3'h2;
      r.is_ext_move = 1'b1;
    end else begin
      case (op)
        8'hB2, 8'h92: begin
          r.nbytes = 2'h2;
          r.ncycles = 3'h2;
        end
        8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2: begin
          r.nbytes = 2'h2;
          r.ncycles = 3'h2;
          r.writes_carry = 1'b1;
        end
        8'h12, 8'h02: begin
          r.nbytes = 2'h3;
          r.ncycles = 3'h4;
        end
        8'h22, 8'h32: r.ncycles = 3'h4;
        8'h80, 8'h40, 8'h50, 8'h60, 8'h70: begin
          r.nbytes = 2'h2;
          r.ncycles = 3'h3;
        end
        8'h73: r.ncycles = 3'h3;
        8'h10, 8'h20, 8'h30, 8'hB5, 8'hB4, 8'hD5: begin
          r.nbytes = 2'h3;
          r.ncycles = 3'h4;
          r.writes_carry = (op == 8'hB5 || op == 8'hB4);
        end
        8'h00, 8'hA5: r.is_nop = 1'b1;
        default: r.nbytes = 2'h1;
      endcase
    end
    return r;
  endfunction

  // Register file: pointer bytes, select bit and cycle control
  logic [7:0] p0l_q, p0l_d, p0h_q, p0h_d, p1l_q, p1l_d, p1h_q, p1h_d;
  logic sel_q, sel_d;
  logic [7:0] cc_q, cc_d;
  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    p0l_d = p0l_q;
    p0h_d = p0h_q;
    p1l_d = p1l_q;
    p1h_d = p1h_q;
    sel_d = sel_q;
    cc_d = cc_q;
    if (sfr_req.wr) begin
      case (sfr_req.addr)
        `SFR_PTR0_LOW: p0l_d = sfr_req.wdata;
        `SFR_PTR0_HIGH: p0h_d = sfr_req.wdata;
        `SFR_PTR1_LOW: p1l_d = sfr_req.wdata;
        `SFR_PTR1_HIGH: p1h_d = sfr_req.wdata;
        `SFR_PTR_SELECT: sel_d = sfr_req.wdata[0];
        `SFR_CYCLE_CONTROL: cc_d = {4'h0, sfr_req.wdata[3:0]};
        default: cc_d = cc_q;
      endcase
    end else if (sfr_req.inc && sfr_req.addr == `SFR_PTR_SELECT) begin
      sel_d = ~sel_q;
    end
    case (sfr_req.addr)
      `SFR_PTR0_LOW: rdata_d = p0l_q;
      `SFR_PTR0_HIGH: rdata_d = p0h_q;
      `SFR_PTR1_LOW: rdata_d = p1l_q;
      `SFR_PTR1_HIGH: rdata_d = p1h_q;
      `SFR_PTR_SELECT: rdata_d = {7'h00, sel_q};
      `SFR_CYCLE_CONTROL: rdata_d = cc_q;
      default: rdata_d = 8'h00;
    endcase
    if (!sfr_req.rd) rdata_d = rdata_q;
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      p0l_q <= 8'h00;
      p0h_q <= 8'h00;
      p1l_q <= 8'h00;
      p1h_q <= 8'h00;
      sel_q <= 1'b0;
      cc_q <= `CYCLE_CONTROL_RESET;
      rdata_q <= 8'h00;
    end else begin
      p0l_q <= p0l_d;
      p0h_q <= p0h_d;
      p1l_q <= p1l_d;
      p1h_q <= p1h_d;
      sel_q <= sel_d;
      cc_q <= cc_d;
      rdata_q <= rdata_d;
    end
  end
  assign sfr_rdata = rdata_q;

  // Timer prescale and instruction-cycle phase
  logic [1:0] phase_q, phase_d;
  logic [3:0] tdiv_q, tdiv_d;
  logic tick_q, tick_d;
  logic [3:0] tick_period;
  always_comb begin
    tick_period = cc_q[`TIMER_FAST_BIT] ? `CLOCKS_PER_TICK_FAST : `CLOCKS_PER_TICK_SLOW;
    tdiv_d = (tdiv_q >= tick_period - 4'h1) ? 4'h0 : tdiv_q + 4'h1;
    tick_d = (tdiv_q >= tick_period - 4'h1);
  end

  // Sequencer: run for plain opcodes, strobe for external data moves
  exec_state_type st_q, st_d;
  logic [3:0] icnt_q, icnt_d;
  logic [4:0] scnt_q, scnt_d;
  logic [15:0] actptr_q, actptr_d;
  logic [1:0] bytes_q, bytes_d;
  logic carry_q, carry_d, done_q, done_d, strobe_q, strobe_d, busy_q, busy_d, ict_q, ict_d;
  op_info_type info;
  logic [2:0] stretch;
  logic icycle_end;
  always_comb begin
    info = decode(opcode);
    stretch = cc_q[`STRETCH_MSB:`STRETCH_LSB];
    icycle_end = (phase_q == 2'(`CLOCKS_PER_ICYCLE - 3'h1));
    phase_d = (st_q == idle_st) ? 2'h0 : phase_q + 2'h1;
    st_d = st_q;
    icnt_d = icnt_q;
    scnt_d = scnt_q;
    bytes_d = bytes_q;
    carry_d = carry_q;
    done_d = 1'b0;
    strobe_d = 1'b0;
    ict_d = (st_q != idle_st) && icycle_end;
    actptr_d = sel_q ? {p1h_q, p1l_q} : {p0h_q, p0l_q};
    case (st_q)
      idle_st: begin
        if (op_start) begin
          bytes_d = info.nbytes;
          carry_d = info.writes_carry;
          // Stretch sampled at start; later writes hit the next access
          icnt_d = info.is_ext_move ? `EXT_MOVE_BASE_CYCLES + {1'b0, stretch}
                                    : {1'b0, info.ncycles};
          // Strobe width: 2 clocks at zero, else 4 per step
          scnt_d = (stretch == 3'h0) ? 5'h02 : {stretch, 2'b00};
          st_d = info.is_ext_move ? strobe_st : run_st;
        end
      end
      run_st: begin
        if (icycle_end) begin
          icnt_d = icnt_q - 4'h1;
          if (icnt_q == 4'h1) begin
            st_d = idle_st;
            done_d = 1'b1;
          end
        end
      end
      strobe_st: begin
        if (scnt_q != 5'h00) begin
          strobe_d = 1'b1;
          scnt_d = scnt_q - 5'h01;
        end
        if (icycle_end) begin
          icnt_d = icnt_q - 4'h1;
          if (icnt_q == 4'h1) begin
            st_d = idle_st;
            done_d = 1'b1;
          end
        end
      end
      default: st_d = idle_st;
    endcase
    busy_d = (st_d != idle_st);
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= idle_st;
      phase_q <= 2'h0;
      tdiv_q <= 4'h0;
      tick_q <= 1'b0;
      icnt_q <= 4'h0;
      scnt_q <= 5'h00;
      bytes_q <= 2'h0;
      carry_q <= 1'b0;
      done_q <= 1'b0;
      strobe_q <= 1'b0;
      busy_q <= 1'b0;
      ict_q <= 1'b0;
      actptr_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      phase_q <= phase_d;
      tdiv_q <= tdiv_d;
      tick_q <= tick_d;
      icnt_q <= icnt_d;
      scnt_q <= scnt_d;
      bytes_q <= bytes_d;
      carry_q <= carry_d;
      done_q <= done_d;
      strobe_q <= strobe_d;
      busy_q <= busy_d;
      ict_q <= ict_d;
      actptr_q <= actptr_d;
    end
  end
  assign active_data_pointer = actptr_q;
  assign op_bytes = bytes_q;
  assign op_writes_carry = carry_q;
  assign op_busy = busy_q;
  assign op_done = done_q;
  assign icycle_tick = ict_q;
  assign timer_tick = tick_q;
  assign data_strobe = strobe_q;

  // Done shows 4 * cycles + 1 clocks after the start edge
  logic move_start;
  assign move_start = st_q == idle_st && op_start
    && opcode inside {8'hE0, 8'hF0, 8'hE2, 8'hE3, 8'hF2, 8'hF3};
  chk_reset_stretch: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> cc_q[`STRETCH_MSB:`STRETCH_LSB] == 3'h1)
    else $error("stretch not one after reset");
  chk_sel_toggle: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sfr_req.inc && !sfr_req.wr && sfr_req.addr == `SFR_PTR_SELECT) |=> sel_q != $past(sel_q))
    else $error("select did not toggle");
  chk_nop_one: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == idle_st && op_start && opcode == 8'hA5) |=> !op_done [*4] ##1 op_done)
    else $error("nop not one cycle");
  chk_call_four: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == idle_st && op_start && opcode == 8'h12) |=> !op_done [*8] ##1 !op_done [*8] ##1 op_done)
    else $error("long call not four cycles");
  chk_jump_three: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == idle_st && op_start && opcode == 8'h80) |=> !op_done [*8] ##1 !op_done [*4] ##1 op_done)
    else $error("short jump not three cycles");
  chk_fast_move: assert property (@(posedge core_clk) disable iff (sys_rst)
    (move_start && cc_q[2:0] == 3'h0) |=> ##1 data_strobe [*2] ##1 !data_strobe)
    else $error("strobe width wrong");
  chk_slow_move: assert property (@(posedge core_clk) disable iff (sys_rst)
    (move_start && cc_q[2:0] == 3'h1) |=> ##1 data_strobe [*4] ##1 !data_strobe)
    else $error("stretched strobe width wrong");
  chk_move_base: assert property (@(posedge core_clk) disable iff (sys_rst)
    (move_start && cc_q[2:0] == 3'h0) |=> !op_done [*8] ##1 op_done)
    else $error("fast move not two cycles");
  chk_strobe_data: assert property (@(posedge core_clk) disable iff (sys_rst)
    data_strobe |-> $past(st_q) == strobe_st)
    else $error("strobe outside data move");
  chk_sel_upper: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sfr_req.rd && sfr_req.addr == `SFR_PTR_SELECT) |=> sfr_rdata[7:1] == 7'h00)
    else $error("select upper bits nonzero");
  chk_ptr_pick: assert property (@(posedge core_clk) disable iff (sys_rst)
    sel_q |=> active_data_pointer == {$past(p1h_q), $past(p1l_q)})
    else $error("wrong pointer active");
  chk_ptr_first: assert property (@(posedge core_clk) disable iff (sys_rst)
    !sel_q |=> active_data_pointer == {$past(p0h_q), $past(p0l_q)})
    else $error("first pointer not active");
  chk_rd_first: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sfr_req.rd && sfr_req.addr == `SFR_PTR0_LOW) |=> sfr_rdata == $past(p0l_q))
    else $error("first pointer low byte read wrong");
  chk_rd_second: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sfr_req.rd && sfr_req.addr == `SFR_PTR1_HIGH) |=> sfr_rdata == $past(p1h_q))
    else $error("second pointer high byte read wrong");
  chk_cmp_carry: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == idle_st && op_start && opcode == 8'hB4) |=> op_writes_carry && op_bytes == 2'h3)
    else $error("compare jump decode wrong");
  chk_busy_start: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == idle_st && op_start) |=> op_busy)
    else $error("busy not raised at start");
  chk_done_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    op_done |-> !op_busy)
    else $error("busy still high at done");
  chk_icycle_gap: assert property (@(posedge core_clk) disable iff (sys_rst)
    icycle_tick |=> !icycle_tick [*3])
    else $error("instruction cycle shorter than four clocks");
  // Main scenarios
  cov_ext_move: cover property (@(posedge core_clk) st_q == strobe_st ##1 op_done);
  cov_sel_inc: cover property (@(posedge core_clk)
    sfr_req.inc && sfr_req.addr == `SFR_PTR_SELECT);
  cov_fast_timer: cover property (@(posedge core_clk) cc_q[`TIMER_FAST_BIT] && timer_tick);
  cov_stretch_max: cover property (@(posedge core_clk) st_q == strobe_st && cc_q[2:0] == 3'h7);
  cov_long_call: cover property (@(posedge core_clk) op_done && op_bytes == 2'h3);
endmodule
`default_nettype wire

// >>> branch_timing_cfg.svh
// Function
// - Carry/bit logic opcodes: two bytes, two cycles
// - Calls three/four cycles, returns four cycles
// - Jump forms with documented bytes and cycles
// - Carry and accumulator conditional jumps, three cycles
// - Bit-test jumps: three bytes, four cycles
// - Compare-jump-unequal forms, four cycles, update carry
// - Decrement-jump-nonzero register and direct forms
// - Opcodes 00 and A5 are one-cycle no-ops
// - Instruction cycle lasts four clocks
// - Timer tick every twelve clocks, optionally four
// - External data move takes two plus stretch
// - Stretch in cycle_control low three bits
// - Stretch resets to one
// - Stretch affects data accesses, not fetches
// - Strobe width 2, then four per step
// - Stretch may change anytime, applies next access
// - First pointer at 0x82/0x83
// - Second pointer at 0x84/0x85
// - Select bit 0 at 0x86 picks pointer
// - Incrementing select toggles bit 0
`ifndef BRANCH_TIMING_CFG_SVH
`define BRANCH_TIMING_CFG_SVH
`define SFR_PTR0_LOW 8'h82
`define SFR_PTR0_HIGH 8'h83
`define SFR_PTR1_LOW 8'h84
`define SFR_PTR1_HIGH 8'h85
`define SFR_PTR_SELECT 8'h86
`define SFR_CYCLE_CONTROL 8'h8E
`define STRETCH_LSB 0
`define STRETCH_MSB 2
`define TIMER_FAST_BIT 3
`define CYCLE_CONTROL_RESET 8'h01
`define CLOCKS_PER_ICYCLE 3'h4
`define CLOCKS_PER_TICK_SLOW 4'hC
`define CLOCKS_PER_TICK_FAST 4'h4
`define EXT_MOVE_BASE_CYCLES 4'h2
`endif

// >>> branch_timing_pkg.sv
package branch_timing_pkg;
  typedef struct packed {
    logic [1:0] nbytes;
    logic [2:0] ncycles;
    logic is_ext_move;
    logic writes_carry;
    logic is_nop;
  } op_info_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic inc;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;
  typedef enum logic [1:0] {
    idle_st, run_st, strobe_st
  } exec_state_type;
endpackage

// >>> ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic data_strobe,
  output logic [4:0] strobe_width
);
  logic [4:0] run_q;
  // Slow memory sees only the strobe; reports its last width
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 5'h00;
      strobe_width <= 5'h00;
    end else if (data_strobe) begin
      run_q <= run_q + 5'h01;
    end else if (run_q != 5'h00) begin
      strobe_width <= run_q;
      run_q <= 5'h00;
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import branch_timing_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  sfr_req_type sfr_req = '0;
  logic op_start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] sfr_rdata, q;
  logic [15:0] active_data_pointer, p0, p1;
  logic [1:0] op_bytes;
  logic op_writes_carry, op_busy, op_done, icycle_tick, timer_tick, data_strobe;
  logic [4:0] strobe_width;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] tbl [32] = '{8'h00, 8'hA5, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92,
    8'h11, 8'hF1, 8'h01, 8'hE1, 8'h12, 8'h22, 8'h32, 8'h02, 8'h80, 8'h73, 8'h40, 8'h50,
    8'h60, 8'h70, 8'h10, 8'h20, 8'h30, 8'hB5, 8'hB4, 8'hBA, 8'hB6, 8'hDC, 8'hD5};
  logic [7:0] ext [6] = '{8'hE0, 8'hF0, 8'hE2, 8'hE3, 8'hF2, 8'hF3};
  always #2 core_clk = ~core_clk;
  branch_timing_core branch_timing_core_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .sfr_req(sfr_req), .op_start(op_start), .opcode(opcode), .sfr_rdata(sfr_rdata),
    .active_data_pointer(active_data_pointer), .op_bytes(op_bytes),
    .op_writes_carry(op_writes_carry), .op_busy(op_busy), .op_done(op_done),
    .icycle_tick(icycle_tick), .timer_tick(timer_tick), .data_strobe(data_strobe));
  ext_mem_model ext_mem_model_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .data_strobe(data_strobe), .strobe_width(strobe_width));
  // Expected {carry, bytes, cycles}
  function automatic logic [6:0] expd(input logic [7:0] op, input logic [2:0] s);
    casez (op)
      8'h00, 8'hA5: return {1'b0, 2'h1, 4'h1};
      8'hB2, 8'h92: return {1'b0, 2'h2, 4'h2};
      8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2: return {1'b1, 2'h2, 4'h2};
      8'h?1, 8'h80, 8'h40, 8'h50, 8'h60, 8'h70, 8'b11011???: return {1'b0, 2'h2, 4'h3};
      8'h12, 8'h02, 8'h10, 8'h20, 8'h30, 8'hD5: return {1'b0, 2'h3, 4'h4};
      8'h22, 8'h32: return {1'b0, 2'h1, 4'h4};
      8'h73: return {1'b0, 2'h1, 4'h3};
      8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'b10111???: return {1'b1, 2'h3, 4'h4};
      default: return {1'b0, 2'h1, 4'h2 + {1'b0, s}};
    endcase
  endfunction
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic sfr(input logic w, r, i, input logic [7:0] a, d);
    @(negedge core_clk);
    sfr_req = '{wr: w, rd: r, inc: i, addr: a, wdata: d};
    @(negedge core_clk);
    sfr_req = '0;
    q = sfr_rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, e);
    sfr(1'b0, 1'b1, 1'b0, a, 8'h00);
    chk(q === e, "register readback");
  endtask
  task automatic run_op(input logic [7:0] op, input logic [2:0] s, input bit poke);
    int k;
    int t;
    logic [6:0] e;
    e = expd(op, s);
    @(negedge core_clk);
    op_start = 1'b1;
    opcode = op;
    k = 0;
    t = 0;
    do begin
      @(negedge core_clk);
      k++;
      if (k == 1) chk(op_busy === 1'b1, "busy after start");
      op_start = poke && k == 2;
      opcode = poke ? 8'h12 : op;
      t += icycle_tick;
    end while (op_done !== 1'b1 && k < 60);
    op_start = 1'b0;
    chk(op_busy === 1'b0, "busy after done");
    chk(k == 4 * e[3:0] + 1, "completion time");
    chk(t == e[3:0], "instruction cycle ticks");
    chk(op_bytes === e[5:4], "byte count");
    chk(op_writes_carry === e[6], "carry update");
    if (e[3:0] != 4'h2 + s || op inside {8'hB2, 8'h92, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2})
      return;
    @(negedge core_clk);
    chk(strobe_width === (s == 3'h0 ? 5'h02 : {s, 2'b00}), "strobe width");
  endtask
  task automatic gap(input int e);
    int n;
    n = 0;
    while (timer_tick !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (timer_tick !== 1'b1 && n < 40);
    chk(n == e, "timer tick spacing");
  endtask
  initial begin
    #80000;
    err_total++;
    print_verdict();
  end
  initial begin
    void'($urandom(85597));
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    rd_chk(8'h8E, 8'h01);
    foreach (tbl[i]) if (i < 5) rd_chk(8'h82 + 8'(i), 8'h00);
    rd_chk(8'h87, 8'h00);
    p0 = 16'($urandom);
    p1 = 16'($urandom);
    sfr(1'b1, 1'b0, 1'b0, 8'h82, p0[7:0]);
    sfr(1'b1, 1'b0, 1'b0, 8'h83, p0[15:8]);
    sfr(1'b1, 1'b0, 1'b0, 8'h84, p1[7:0]);
    sfr(1'b1, 1'b0, 1'b0, 8'h85, p1[15:8]);
    rd_chk(8'h83, p0[15:8]);
    rd_chk(8'h84, p1[7:0]);
    chk(active_data_pointer === p0, "first pointer active");
    sfr(1'b1, 1'b0, 1'b0, 8'h86, 8'hFF);
    rd_chk(8'h86, 8'h01);
    chk(active_data_pointer === p1, "second pointer active");
    for (int i = 0; i < 2; i++) begin
      sfr(1'b0, 1'b0, 1'b1, 8'h86, 8'h00);
      rd_chk(8'h86, 8'(i));
    end
    gap(12);
    sfr(1'b1, 1'b0, 1'b0, 8'h8E, 8'hF9);
    rd_chk(8'h8E, 8'h09);
    gap(4);
    for (int s = 0; s < 8; s++) begin
      sfr(1'b1, 1'b0, 1'b0, 8'h8E, 8'(s));
      run_op(ext[$urandom_range(5)], 3'(s), 1'b0);
    end
    foreach (tbl[i]) run_op(tbl[i], 3'h7, 1'b0);
    for (int i = 0; i < 20; i++) run_op(tbl[$urandom_range(31)], 3'h7, 1'($urandom));
    print_verdict();
  end
endmodule
`default_nettype wire
